// file: testbench/rsp_link_sva.sv
// checker for the two-wire link joining the master end and the sensor port end
// assumes it sees the signals of one rsp_if, with both design ends attached to it
`timescale 1ns/1ps

module rsp_link_sva #(
  parameter logic [6:0] OWN_ADDR = 7'h40
) (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic scl_h,
  input wire logic scl_oe_n_h,
  input wire logic sda_h,
  input wire logic sda_oe_n_h,
  input wire logic sda_d,
  input wire logic sda_oe_n_d,
  input wire logic scl,
  input wire logic sda
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);

  // ---------------------------------------------------------------
  // frame decode from the wires
  // ---------------------------------------------------------------
  logic scl_r;
  logic sda_r;
  logic [3:0] bitn_r;
  logic [7:0] byte_r;
  logic [7:0] shift_r;
  logic [7:0] addr_r;
  wire rise = scl & ~scl_r;
  wire start = scl & scl_r & sda_r & ~sda;
  wire nine = rise && (bitn_r == 4'h8);
  wire own = (addr_r[7:1] == OWN_ADDR);

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      scl_r <= 1'b1;
      sda_r <= 1'b1;
    end else begin
      scl_r <= scl;
      sda_r <= sda;
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      bitn_r <= 4'h0;
      byte_r <= 8'h00;
      shift_r <= 8'h00;
      addr_r <= 8'h00;
    end else if (start) begin
      bitn_r <= 4'h0;
      byte_r <= 8'h00;
    end else if (rise) begin
      shift_r <= {shift_r[6:0], sda};
      bitn_r <= (bitn_r == 4'h8) ? 4'h0 : bitn_r + 4'h1;
      byte_r <= (bitn_r == 4'h8) ? byte_r + 8'h01 : byte_r;
      if (bitn_r == 4'h7 && byte_r == 8'h00) begin
        addr_r <= {shift_r[6:0], sda};
      end
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  a_own_addr_ack: assert property (nine && byte_r == 8'h00 && own |-> !sda_oe_n_d)
    else $error("own address byte not acknowledged");
  a_foreign_addr_ignored: assert property (nine && byte_r == 8'h00 && !own |-> sda_oe_n_d)
    else $error("foreign address byte acknowledged");
  a_write_byte_ack: assert property (nine && byte_r != 8'h00 && own && !addr_r[0] |-> !sda_oe_n_d)
    else $error("written byte not acknowledged");
  a_write_bits_free: assert property (rise && bitn_r != 4'h8 && byte_r != 8'h00 && !addr_r[0] |-> sda_oe_n_d)
    else $error("port drives data line during master byte");
  a_read_ack_slot_free: assert property (nine && byte_r != 8'h00 && own && addr_r[0] |-> sda_oe_n_d)
    else $error("port holds data line in master ack slot");
  a_data_stable_high: assert property ($changed(sda_oe_n_d) |-> !scl && !$past(scl))
    else $error("port changed data line while clock high");
  a_open_drain_low: assert property (!scl_h && !sda_h && !sda_d)
    else $error("driven level is not low");
  a_release_after_reset: assert property ($rose(i_nrst) |-> scl_oe_n_h && sda_oe_n_h && sda_oe_n_d)
    else $error("line driven at reset release");
endmodule

// file: testbench/tb_top.sv
// self-checking bench: master end and sensor port end joined by rsp_if
// assumes shortened bus quarters; a second link carries a master aimed at another address
`timescale 1ns/1ps

module tb_top
  import rsp_pkg::*;
;
  logic i_clock = 1'b0;
  logic i_nrst = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_valid2 = 1'b0;
  logic cmd_read = 1'b0;
  logic cmd_rstart = 1'b0;
  logic [7:0] cmd_reg = 8'h00;
  logic [7:0] cmd_wdata = 8'h00;
  logic [7:0] cmd_len = 8'h01;
  logic upd_we = 1'b0;
  logic [7:0] upd_addr = 8'h00;
  logic [7:0] upd_data = 8'h00;
  logic [FUSE_BYTES*8-1:0] fuse_image;
  logic cmd_ready, rd_valid, done, nack, done2, nack2, updates_held, wr_pulse, wr_pulse2;
  logic [7:0] rd_data, bank, wr_addr, wr_data;
  logic [7:0] rdq[$];
  int n_errors = 0;
  int checks_done = 0;
  int n_wr = 0;
  int n_wr2 = 0;
  logic watch2 = 1'b0;

  rsp_if bus();
  rsp_if bus2();

  always #5 i_clock = ~i_clock;

  always @(negedge i_clock) begin
    if (wr_pulse === 1'b1) n_wr++;
    if (wr_pulse2 === 1'b1) n_wr2++;
  end

  rsp_host #(.QCYC(12)) rsp_host_i (.i_clock(i_clock), .i_nrst(i_nrst), .bus(bus), .i_cmd_valid(cmd_valid),
    .o_cmd_ready(cmd_ready), .i_cmd_read(cmd_read), .i_cmd_rstart(cmd_rstart), .i_cmd_reg(cmd_reg),
    .i_cmd_wdata(cmd_wdata), .i_cmd_len(cmd_len), .o_rd_valid(rd_valid), .o_rd_data(rd_data), .o_done(done),
    .o_nack(nack));
  rsp_device rsp_device_i (.i_clock(i_clock), .i_nrst(i_nrst), .bus(bus), .i_upd_we(upd_we),
    .i_upd_addr(upd_addr), .i_upd_data(upd_data), .i_fuse_image(fuse_image), .o_updates_held(updates_held),
    .o_bank(bank), .o_wr_pulse(wr_pulse), .o_wr_addr(wr_addr), .o_wr_data(wr_data));
  // checker follows the second link during the foreign-address scenario; both links are idle at the switch
  rsp_link_sva #(.OWN_ADDR(7'h40)) rsp_link_sva_i (.i_clock(i_clock), .i_nrst(i_nrst),
    .scl_h(watch2 ? bus2.scl_h : bus.scl_h), .scl_oe_n_h(watch2 ? bus2.scl_oe_n_h : bus.scl_oe_n_h),
    .sda_h(watch2 ? bus2.sda_h : bus.sda_h), .sda_oe_n_h(watch2 ? bus2.sda_oe_n_h : bus.sda_oe_n_h),
    .sda_d(watch2 ? bus2.sda_d : bus.sda_d), .sda_oe_n_d(watch2 ? bus2.sda_oe_n_d : bus.sda_oe_n_d),
    .scl(watch2 ? bus2.scl : bus.scl), .sda(watch2 ? bus2.sda : bus.sda));
  rsp_host #(.DEV_ADDR(7'h22), .QCYC(12)) rsp_host2_i (.i_clock(i_clock), .i_nrst(i_nrst), .bus(bus2),
    .i_cmd_valid(cmd_valid2), .o_cmd_ready(), .i_cmd_read(cmd_read), .i_cmd_rstart(cmd_rstart),
    .i_cmd_reg(cmd_reg), .i_cmd_wdata(cmd_wdata), .i_cmd_len(cmd_len), .o_rd_valid(), .o_rd_data(),
    .o_done(done2), .o_nack(nack2));
  rsp_device rsp_device2_i (.i_clock(i_clock), .i_nrst(i_nrst), .bus(bus2), .i_upd_we(upd_we),
    .i_upd_addr(upd_addr), .i_upd_data(upd_data), .i_fuse_image(fuse_image), .o_updates_held(),
    .o_bank(), .o_wr_pulse(wr_pulse2), .o_wr_addr(), .o_wr_data());

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one command on either master; read bytes of the first master are collected in rdq
  task automatic run_cmd(input logic sel2, input logic rd, input logic rs, input logic [7:0] rg,
    input logic [7:0] wd, input logic [7:0] ln);
    int k;
    rdq = {};
    @(negedge i_clock);
    cmd_read = rd;
    cmd_rstart = rs;
    cmd_reg = rg;
    cmd_wdata = wd;
    cmd_len = ln;
    if (sel2) cmd_valid2 = 1'b1;
    else cmd_valid = 1'b1;
    @(negedge i_clock);
    cmd_valid = 1'b0;
    cmd_valid2 = 1'b0;
    for (k = 0; k < 8000; k++) begin
      @(negedge i_clock);
      if (rd_valid === 1'b1) rdq.push_back(rd_data);
      if ((sel2 ? done2 : done) === 1'b1) break;
    end
    if (k == 8000) begin
      n_errors++;
      $display("ERROR cmd_done expected 1 seen 0");
      close_out();
    end
  endtask

  task automatic bus_write(input logic [7:0] rg, input logic [7:0] wd);
    int w0;
    w0 = n_wr;
    run_cmd(1'b0, 1'b0, 1'b0, rg, wd, 8'h01);
    check("wr_count", 8'(n_wr - w0), 8'h01);
    check("wr_addr", wr_addr, rg);
    check("wr_data", wr_data, wd);
    check("nack", {7'h00, nack}, 8'h00);
  endtask

  task automatic bus_read(input logic [7:0] rg, input logic [7:0] ln, input logic rs, input logic [7:0] ex[$]);
    run_cmd(1'b0, 1'b1, rs, rg, 8'h00, ln);
    check("rd_count", 8'(rdq.size()), 8'(ex.size()));
    check("nack", {7'h00, nack}, 8'h00);
    foreach (ex[i]) check("rd_data", (i < rdq.size()) ? rdq[i] : 8'hxx, ex[i]);
  endtask

  task automatic upd(input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clock);
    upd_we = 1'b1;
    upd_addr = a;
    upd_data = d;
    @(negedge i_clock);
    upd_we = 1'b0;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic sc_reset_values();
    check("bank", bank, 8'h00);
    check("held", {7'h00, updates_held}, 8'h00);
    check("ready", {7'h00, cmd_ready}, 8'h01);
    bus_read(8'h03, 8'h01, 1'b0, '{8'h01});
  endtask

  task automatic sc_freeze();
    bus_write(8'h10, 8'h11);
    bus_write(8'h03, 8'h00);
    check("held", {7'h00, updates_held}, 8'h01);
    upd(8'h10, 8'h77);
    bus_read(8'h10, 8'h01, 1'b0, '{8'h11});
    bus_write(8'h03, 8'h01);
    check("held", {7'h00, updates_held}, 8'h00);
    upd(8'h10, 8'h77);
    bus_read(8'h10, 8'h01, 1'b1, '{8'h77});
  endtask

  task automatic sc_burst();
    upd(8'h20, 8'h3c);
    upd(8'h21, 8'hc3);
    upd(8'h22, 8'h5a);
    bus_read(8'h20, 8'h03, 1'b0, '{8'h3c, 8'hc3, 8'h5a});
    bus_read(8'h21, 8'h02, 1'b1, '{8'hc3, 8'h5a});
  endtask

  task automatic sc_bank();
    bus_write(8'hef, 8'h03);
    check("bank", bank, 8'h03);
    bus_read(8'h00, 8'h02, 1'b1, '{fuse_image[7:0], fuse_image[15:8]});
    bus_read(8'hef, 8'h01, 1'b0, '{8'h03});
    bus_write(8'hef, 8'h00);
    check("bank", bank, 8'h00);
    bus_read(8'h20, 8'h01, 1'b1, '{8'h3c});
  endtask

  task automatic sc_foreign();
    int w0;
    w0 = n_wr2;
    watch2 = 1'b1;
    run_cmd(1'b1, 1'b0, 1'b0, 8'h10, 8'h99, 8'h01);
    watch2 = 1'b0;
    check("nack2", {7'h00, nack2}, 8'h01);
    check("wr_count2", 8'(n_wr2 - w0), 8'h00);
  endtask

  initial begin
    for (int k = 0; k < FUSE_BYTES; k++) fuse_image[8*k +: 8] = 8'(k) ^ 8'ha5;
    repeat (3) @(negedge i_clock);
    i_nrst = 1'b1;
    repeat (12) @(negedge i_clock);
    sc_reset_values();
    sc_freeze();
    sc_burst();
    sc_bank();
    sc_foreign();
    close_out();
  end
endmodule

// file: verilog/rsp_device.sv
// sensor end of the two-wire register port: slave engine, bank select, update freeze
// assumes the link pins arrive asynchronous to i_clock and are resolved by rsp_if
//
// Summary of operation
// - write address, ack, register address, ack, optional stop
// - read address with direction high is acknowledged
// - read returns byte from latched register address
// - master ends single read with nack, stop
// - master ack continues read, nack ends it
// - burst bytes come from address plus one, two
// - repeated start keeps latched address, no stop
// - bank choice 0 primary, 3 fuse mirror
// - primary bank control, fuse bank mirrors fuse
// - freeze bit resets one; zero blocks updates
// - spikes up to 50 ns filtered on inputs
// - write: address, register, data, each acked, stop

`timescale 1ns/1ps

module rsp_device
  import rsp_pkg::*;
#(
  parameter logic [6:0] OWN_ADDR = BUS_ADDRESS_WRITE_FORM[7:1],
  parameter int FILT_CYC = SPIKE_CYC
) (
  input wire logic i_clock,
  input wire logic i_nrst,
  rsp_if.dev bus,
  input wire logic i_upd_we,
  input wire logic [7:0] i_upd_addr,
  input wire logic [7:0] i_upd_data,
  input wire logic [FUSE_BYTES*8-1:0] i_fuse_image,
  output logic o_updates_held,
  output logic [7:0] o_bank,
  output logic o_wr_pulse,
  output logic [7:0] o_wr_addr,
  output logic [7:0] o_wr_data
);

  // ---------------------------------------------------------------
  // input synchronisers and spike filter
  // ---------------------------------------------------------------
  logic [1:0] sync1_r;
  logic [1:0] sync2_r;
  logic [1:0] filt_r;
  logic [1:0] filt_prev_r;
  logic [3:0] fcnt_r [2];

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      sync1_r <= 2'b11;
      sync2_r <= 2'b11;
    end else begin
      sync1_r <= {bus.scl, bus.sda};
      sync2_r <= sync1_r;
    end
  end

  // a new level is taken only after it has held for more than the spike width
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      filt_r <= 2'b11;
      filt_prev_r <= 2'b11;
      fcnt_r[0] <= 4'h0;
      fcnt_r[1] <= 4'h0;
    end else begin
      filt_prev_r <= filt_r;
      for (int i = 0; i < 2; i++) begin
        if (sync2_r[i] == filt_r[i]) begin
          fcnt_r[i] <= 4'h0;
        end else if (fcnt_r[i] == 4'(FILT_CYC)) begin
          filt_r[i] <= sync2_r[i];
          fcnt_r[i] <= 4'h0;
        end else begin
          fcnt_r[i] <= fcnt_r[i] + 4'h1;
        end
      end
    end
  end

  logic scl_f;
  logic sda_f;
  logic start_c;
  logic stop_c;
  logic rise_c;
  logic fall_c;

  assign scl_f = filt_r[1];
  assign sda_f = filt_r[0];
  assign start_c = scl_f & filt_prev_r[1] & filt_prev_r[0] & ~sda_f;
  assign stop_c = scl_f & filt_prev_r[1] & ~filt_prev_r[0] & sda_f;
  assign rise_c = scl_f & ~filt_prev_r[1];
  assign fall_c = ~scl_f & filt_prev_r[1];

  // ---------------------------------------------------------------
  // register storage
  // ---------------------------------------------------------------
  logic [7:0] mem [256];
  logic freeze_r;
  logic [7:0] bank_r;
  logic [7:0] ptr_r;
  logic [7:0] rd_byte;
  logic fuse_sel;

  assign fuse_sel = (bank_r == BANK_FUSE_MIRROR);

  // byte presented at the current pointer
  always_comb begin
    if (ptr_r == REG_REGISTER_BANK_CHOICE) begin
      rd_byte = bank_r;
    end else if (fuse_sel) begin
      rd_byte = (ptr_r < 8'(FUSE_BYTES)) ? i_fuse_image[{ptr_r[FUSE_AW-1:0], 3'b000} +: 8] : 8'h00;
    end else if (ptr_r == REG_UPDATE_FREEZE_CONTROL) begin
      rd_byte = {7'h00, freeze_r};
    end else begin
      rd_byte = mem[ptr_r];
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      freeze_r <= UPDATE_FREEZE_RESET[UPDATE_FREEZE_BIT];
      bank_r <= REGISTER_BANK_RESET;
    end else if (o_wr_pulse) begin
      if (o_wr_addr == REG_REGISTER_BANK_CHOICE) begin
        bank_r <= o_wr_data;
      end else if (!fuse_sel && o_wr_addr == REG_UPDATE_FREEZE_CONTROL) begin
        freeze_r <= o_wr_data[UPDATE_FREEZE_BIT];
      end
    end
  end

  // bus writes land in the primary bank only; the fuse mirror is read-only
  always_ff @(posedge i_clock) begin
    if (o_wr_pulse) begin
      if (!fuse_sel) begin
        mem[o_wr_addr] <= o_wr_data;
      end
    end else if (i_upd_we && freeze_r) begin
      mem[i_upd_addr] <= i_upd_data;
    end
  end

  assign o_updates_held = ~freeze_r;
  assign o_bank = bank_r;

  // ---------------------------------------------------------------
  // slave engine
  // ---------------------------------------------------------------
  rsp_dev_state_t st_r;
  logic [3:0] cnt_r;
  logic [7:0] sr_r;
  logic [7:0] txb_r;
  logic rw_r;
  logic reg_phase_r;
  logic acked_r;
  logic sda_oe_n_r;
  logic [7:0] rx_byte;

  assign rx_byte = sr_r;

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      st_r <= D_IDLE;
      cnt_r <= 4'h0;
      sr_r <= 8'h00;
      txb_r <= 8'h00;
      rw_r <= 1'b0;
      reg_phase_r <= 1'b0;
      acked_r <= 1'b0;
      ptr_r <= 8'h00;
      sda_oe_n_r <= 1'b1;
      o_wr_pulse <= 1'b0;
      o_wr_addr <= 8'h00;
      o_wr_data <= 8'h00;
    end else begin
      o_wr_pulse <= 1'b0;
      if (start_c) begin
        // a repeated start leaves the pointer as latched
        st_r <= D_ADDR;
        cnt_r <= 4'h0;
        reg_phase_r <= 1'b1;
        sda_oe_n_r <= 1'b1;
      end else if (stop_c) begin
        st_r <= D_IDLE;
        sda_oe_n_r <= 1'b1;
      end else begin
        case (st_r)
          D_ADDR, D_RX: begin
            if (rise_c) begin
              sr_r <= {sr_r[6:0], sda_f};
              cnt_r <= cnt_r + 4'h1;
            end else if (fall_c && cnt_r == 4'h8) begin
              if (st_r == D_ADDR) begin
                if (rx_byte[7:1] == OWN_ADDR) begin
                  rw_r <= rx_byte[0];
                  sda_oe_n_r <= 1'b0;
                  st_r <= D_ACK;
                end else begin
                  st_r <= D_WAIT;
                end
              end else begin
                if (reg_phase_r) begin
                  ptr_r <= rx_byte;
                  reg_phase_r <= 1'b0;
                end else begin
                  o_wr_pulse <= 1'b1;
                  o_wr_addr <= ptr_r;
                  o_wr_data <= rx_byte;
                  ptr_r <= ptr_r + 8'h01;
                end
                sda_oe_n_r <= 1'b0;
                st_r <= D_ACK;
              end
            end
          end
          D_ACK: begin
            if (fall_c) begin
              cnt_r <= 4'h0;
              if (rw_r) begin
                txb_r <= rd_byte;
                sda_oe_n_r <= rd_byte[7];
                ptr_r <= ptr_r + 8'h01;
                cnt_r <= 4'h1;
                st_r <= D_TX;
              end else begin
                sda_oe_n_r <= 1'b1;
                st_r <= D_RX;
              end
            end
          end
          D_TX: begin
            if (fall_c) begin
              if (cnt_r == 4'h8) begin
                sda_oe_n_r <= 1'b1;
                st_r <= D_MACK;
              end else begin
                txb_r <= {txb_r[6:0], 1'b0};
                sda_oe_n_r <= txb_r[6];
                cnt_r <= cnt_r + 4'h1;
              end
            end
          end
          D_MACK: begin
            if (rise_c) begin
              acked_r <= ~sda_f;
            end else if (fall_c) begin
              if (acked_r) begin
                txb_r <= rd_byte;
                sda_oe_n_r <= rd_byte[7];
                ptr_r <= ptr_r + 8'h01;
                cnt_r <= 4'h1;
                st_r <= D_TX;
              end else begin
                st_r <= D_WAIT;
              end
            end
          end
          D_IDLE, D_WAIT: begin
            sda_oe_n_r <= 1'b1;
          end
          default: begin
            st_r <= D_IDLE;
            sda_oe_n_r <= 1'b1;
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // pin drive
  // ---------------------------------------------------------------
  assign bus.sda_d = 1'b0;
  assign bus.sda_oe_n_d = sda_oe_n_r;

endmodule

// file: verilog/rsp_host.sv
// bus master end of the two-wire register port: one command per write or read burst
// assumes a single master; the far end never stretches the clock line

`timescale 1ns/1ps

module rsp_host
  import rsp_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = BUS_ADDRESS_WRITE_FORM[7:1],
  parameter int QCYC = QUARTER_CYC
) (
  input wire logic i_clock,
  input wire logic i_nrst,
  rsp_if.host bus,
  input wire logic i_cmd_valid,
  output logic o_cmd_ready,
  input wire logic i_cmd_read,
  input wire logic i_cmd_rstart,
  input wire logic [7:0] i_cmd_reg,
  input wire logic [7:0] i_cmd_wdata,
  input wire logic [7:0] i_cmd_len,
  output logic o_rd_valid,
  output logic [7:0] o_rd_data,
  output logic o_done,
  output logic o_nack
);

  // ---------------------------------------------------------------
  // data line synchroniser
  // ---------------------------------------------------------------
  logic sda_s1_r;
  logic sda_s2_r;

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
    end else begin
      sda_s1_r <= bus.sda;
      sda_s2_r <= sda_s1_r;
    end
  end

  // ---------------------------------------------------------------
  // quarter-bit timebase
  // ---------------------------------------------------------------
  rsp_host_state_t st_r;
  logic [7:0] qcnt_r;
  logic [1:0] qph_r;
  logic tick;

  assign tick = (qcnt_r == 8'(QCYC - 1));

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      qcnt_r <= 8'h00;
      qph_r <= 2'b00;
    end else if (st_r == H_IDLE) begin
      qcnt_r <= 8'h00;
      qph_r <= 2'b00;
    end else if (tick) begin
      qcnt_r <= 8'h00;
      qph_r <= qph_r + 2'b01;
    end else begin
      qcnt_r <= qcnt_r + 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // transfer sequencer
  // ---------------------------------------------------------------
  rsp_seq_t seq_r;
  logic [3:0] bitn_r;
  logic [7:0] txb_r;
  logic [7:0] rsr_r;
  logic [7:0] left_r;
  logic rd_r;
  logic rstart_r;
  logic [7:0] reg_r;
  logic [7:0] wd_r;
  logic nack_bit_r;
  logic last_rd;

  assign last_rd = (left_r == 8'h01);
  assign o_cmd_ready = (st_r == H_IDLE);

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      st_r <= H_IDLE;
      seq_r <= SQ_AW;
      bitn_r <= 4'h0;
      txb_r <= 8'h00;
      rsr_r <= 8'h00;
      left_r <= 8'h00;
      rd_r <= 1'b0;
      rstart_r <= 1'b0;
      reg_r <= 8'h00;
      wd_r <= 8'h00;
      nack_bit_r <= 1'b0;
      o_rd_valid <= 1'b0;
      o_rd_data <= 8'h00;
      o_done <= 1'b0;
      o_nack <= 1'b0;
    end else begin
      o_rd_valid <= 1'b0;
      o_done <= 1'b0;
      if (st_r == H_IDLE) begin
        if (i_cmd_valid) begin
          rd_r <= i_cmd_read;
          rstart_r <= i_cmd_rstart;
          reg_r <= i_cmd_reg;
          wd_r <= i_cmd_wdata;
          left_r <= (i_cmd_len == 8'h00) ? 8'h01 : i_cmd_len;
          o_nack <= 1'b0;
          seq_r <= SQ_AW;
          st_r <= H_START;
        end
      end else if (tick && qph_r == 2'd2) begin
        nack_bit_r <= sda_s2_r;
        if (st_r == H_RBYTE && bitn_r < 4'h8) begin
          rsr_r <= {rsr_r[6:0], sda_s2_r};
        end
      end else if (tick && qph_r == 2'd3) begin
        case (st_r)
          H_START: begin
            txb_r <= {DEV_ADDR, seq_r == SQ_AR};
            bitn_r <= 4'h0;
            st_r <= H_WBYTE;
          end
          H_WBYTE: begin
            bitn_r <= 4'h0;
            if (bitn_r != 4'h8) begin
              bitn_r <= bitn_r + 4'h1;
              txb_r <= {txb_r[6:0], 1'b0};
            end else if (nack_bit_r) begin
              o_nack <= 1'b1;
              seq_r <= SQ_END;
              st_r <= H_STOP;
            end else begin
              case (seq_r)
                SQ_AW: begin
                  txb_r <= reg_r;
                  seq_r <= SQ_REG;
                end
                SQ_REG: begin
                  if (rd_r) begin
                    seq_r <= SQ_AR;
                    st_r <= rstart_r ? H_START : H_STOP;
                  end else begin
                    txb_r <= wd_r;
                    seq_r <= SQ_WD;
                  end
                end
                SQ_AR: begin
                  seq_r <= SQ_RD;
                  st_r <= H_RBYTE;
                end
                default: begin
                  seq_r <= SQ_END;
                  st_r <= H_STOP;
                end
              endcase
            end
          end
          H_RBYTE: begin
            if (bitn_r != 4'h8) begin
              bitn_r <= bitn_r + 4'h1;
            end else begin
              o_rd_valid <= 1'b1;
              o_rd_data <= rsr_r;
              bitn_r <= 4'h0;
              if (last_rd) begin
                seq_r <= SQ_END;
                st_r <= H_STOP;
              end else begin
                left_r <= left_r - 8'h01;
              end
            end
          end
          H_STOP: begin
            if (seq_r == SQ_AR) begin
              st_r <= H_START;
            end else begin
              o_done <= 1'b1;
              st_r <= H_IDLE;
            end
          end
          default: begin
            st_r <= H_IDLE;
          end
        endcase
      end
    end
  end

  // ---------------------------------------------------------------
  // line levels; data bits move in the second low quarter, start and stop edges in the second high quarter
  // ---------------------------------------------------------------
  logic scl_lo;
  logic sda_lo;
  logic scl_oe_n_r;
  logic sda_oe_n_r;

  always_comb begin
    scl_lo = ~qph_r[1];
    sda_lo = ~sda_oe_n_r;
    case (st_r)
      H_START: begin
        if (qph_r != 2'd0) begin
          sda_lo = (qph_r == 2'd3);
        end
      end
      H_STOP: begin
        if (qph_r != 2'd0) begin
          sda_lo = (qph_r != 2'd3);
        end
      end
      H_WBYTE: begin
        if (qph_r != 2'd0) begin
          sda_lo = (bitn_r < 4'h8) ? ~txb_r[7] : 1'b0;
        end
      end
      H_RBYTE: begin
        if (qph_r != 2'd0) begin
          sda_lo = (bitn_r == 4'h8) ? ~last_rd : 1'b0;
        end
      end
      default: begin
        scl_lo = 1'b0;
        sda_lo = 1'b0;
      end
    endcase
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      scl_oe_n_r <= 1'b1;
      sda_oe_n_r <= 1'b1;
    end else begin
      scl_oe_n_r <= ~scl_lo;
      sda_oe_n_r <= ~sda_lo;
    end
  end

  assign bus.scl_h = 1'b0;
  assign bus.scl_oe_n_h = scl_oe_n_r;
  assign bus.sda_h = 1'b0;
  assign bus.sda_oe_n_h = sda_oe_n_r;

endmodule

// file: verilog/rsp_if.sv
// two-wire link between the bus master end and the sensor port end
// a released line reads high, as with the external pull-up

`timescale 1ns/1ps

interface rsp_if;
  logic scl_h;
  logic scl_oe_n_h;
  logic sda_h;
  logic sda_oe_n_h;
  logic sda_d;
  logic sda_oe_n_d;
  logic scl;
  logic sda;

  // ---------------------------------------------------------------
  // wired-and resolution
  // ---------------------------------------------------------------
  assign scl = scl_oe_n_h | scl_h;
  assign sda = (sda_oe_n_h | sda_h) & (sda_oe_n_d | sda_d);

  modport dev (input scl, input sda, output sda_d, output sda_oe_n_d);
  modport host (input scl, input sda, output scl_h, output scl_oe_n_h, output sda_h, output sda_oe_n_h);
endinterface

// file: verilog/rsp_pkg.sv
// shared constants and types for the two-wire register port of the ranging sensor
// assumes a 100 MHz system clock on both ends of the link

package rsp_pkg;

  // ---------------------------------------------------------------
  // clock and timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int SPIKE_NS = 50;
  localparam int SPIKE_CYC = (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int T_LOW_NS = 1300;
  localparam int QUARTER_CYC = (T_LOW_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // bus address forms and register map
  // ---------------------------------------------------------------
  localparam logic [7:0] BUS_ADDRESS_WRITE_FORM = 8'h80;
  localparam logic [7:0] BUS_ADDRESS_READ_FORM = 8'h81;
  localparam logic [7:0] REG_UPDATE_FREEZE_CONTROL = 8'h03;
  localparam logic [7:0] REG_REGISTER_BANK_CHOICE = 8'hef;
  localparam logic [7:0] UPDATE_FREEZE_RESET = 8'h01;
  localparam int UPDATE_FREEZE_BIT = 0;
  localparam logic [7:0] BANK_PRIMARY_CONTROL = 8'h00;
  localparam logic [7:0] BANK_FUSE_MIRROR = 8'h03;
  localparam logic [7:0] REGISTER_BANK_RESET = 8'h00;
  localparam int FUSE_AW = 6;
  localparam int FUSE_BYTES = 1 << FUSE_AW;

  // ---------------------------------------------------------------
  // state encodings
  // ---------------------------------------------------------------
  typedef enum logic [6:0] {
    D_IDLE = 7'h01,
    D_ADDR = 7'h02,
    D_ACK  = 7'h04,
    D_RX   = 7'h08,
    D_TX   = 7'h10,
    D_MACK = 7'h20,
    D_WAIT = 7'h40
  } rsp_dev_state_t;

  typedef enum logic [4:0] {
    H_IDLE  = 5'h01,
    H_START = 5'h02,
    H_WBYTE = 5'h04,
    H_RBYTE = 5'h08,
    H_STOP  = 5'h10
  } rsp_host_state_t;

  typedef enum logic [5:0] {
    SQ_AW  = 6'h01,
    SQ_REG = 6'h02,
    SQ_WD  = 6'h04,
    SQ_AR  = 6'h08,
    SQ_RD  = 6'h10,
    SQ_END = 6'h20
  } rsp_seq_t;

endpackage
